/* File: design/vsma_top.sv */
`timescale 1ns/1ns
`include "vsma_regs.svh"
module vsma_top
    import vsma_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Mode flags per channel; power cycle shared by both
    input wire logic [1:0] scaling_enable_flag,
    input wire logic [1:0] scaling_startup_flag,
    input wire logic power_cycle,
    // Management bus command port
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_ack,
    // Scaling link address match
    input wire logic [3:0] link_addr,
    output logic link_addr_match,
    // Status and alert
    output logic other_fault,
    input wire logic other_fault_clear,
    output logic alert,
    // Channel modes
    output logic [1:0] chan_mode0,
    output logic [1:0] chan_mode1
);
    // ==========================================
    // Internal state and decode nets
    logic [3:0] scaling_link_id;
    logic [3:0] next_link_id;
    logic next_other_fault;
    logic [15:0] next_rdata;
    logic [1:0] sync1_en;
    logic [1:0] sync2_en;
    logic [1:0] sync1_st;
    logic [1:0] sync2_st;
    logic [1:0] chan_scale;
    logic addr_sel;
    logic wr_addr;
    logic both_scale;
    logic blocked;
    logic store_ok;
    vsma_chan_if chan0 ();
    vsma_chan_if chan1 ();

    // ==========================================
    // Helpers
    // True while a channel sits in plain scaling mode
    function automatic logic is_scaling(input logic [1:0] m);
        return m == VSMA_SCALE;
    endfunction

    // ==========================================
    // Flag synchronisers
    // Enable and startup levels come from outside the clock domain
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_en <= `VSMA_SYNC_RESET;
            sync2_en <= `VSMA_SYNC_RESET;
        end else begin
            sync1_en <= scaling_enable_flag;
            sync2_en <= sync1_en;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_st <= `VSMA_SYNC_RESET;
            sync2_st <= `VSMA_SYNC_RESET;
        end else begin
            sync1_st <= scaling_startup_flag;
            sync2_st <= sync1_st;
        end
    end

    // ==========================================
    // Channel mode machines
    // Only the second synchroniser stage feeds the machines
    assign chan0.enable_flag = sync2_en[0];
    assign chan0.startup_flag = sync2_st[0];
    assign chan0.power_cycle = power_cycle;
    assign chan1.enable_flag = sync2_en[1];
    assign chan1.startup_flag = sync2_st[1];
    assign chan1.power_cycle = power_cycle;

    vsma_mode_fsm u_fsm0 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ch(chan0)
    );
    vsma_mode_fsm u_fsm1 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ch(chan1)
    );

    assign chan_mode0 = chan0.mode;
    assign chan_mode1 = chan1.mode;
    assign chan_scale[0] = is_scaling(chan0.mode);
    assign chan_scale[1] = is_scaling(chan1.mode);

    // ==========================================
    // Command decode
    assign addr_sel = cmd_code == `VSMA_ADDR_CMD;
    assign wr_addr = cmd_write && addr_sel;
    assign both_scale = &chan_scale;
    // Both channels scaling locks the address against writes
    assign blocked = wr_addr && both_scale;
    assign store_ok = wr_addr && !both_scale;
    // Only the low nibble is kept; upper data bits are dropped
    assign next_link_id = store_ok ? cmd_wdata[`VSMA_ID_MSB:0]
        : scaling_link_id;
    // A new lockout event beats a clear in the same cycle
    assign next_other_fault = blocked
        | (other_fault & ~other_fault_clear);
    assign next_rdata = addr_sel ? {`VSMA_RSVD_ZERO, scaling_link_id}
        : `VSMA_RDATA_IDLE;

    // ==========================================
    // Address register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scaling_link_id <= `VSMA_ID_RESET;
        end else begin
            scaling_link_id <= next_link_id;
        end
    end

    // ==========================================
    // Status and read data
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            other_fault <= 1'b0;
        end else begin
            other_fault <= next_other_fault;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_rdata <= `VSMA_RDATA_IDLE;
        end else begin
            cmd_rdata <= next_rdata;
        end
    end

    // ==========================================
    // Handshake, alert and link match
    // Every write is acknowledged, even one that is locked out
    assign cmd_ack = cmd_write;
    assign alert = other_fault;
    // The id is compared with link traffic only, never bus codes
    assign link_addr_match = link_addr == scaling_link_id;

    // ==========================================
    // Assertions
    property p_block;
        @(posedge ref_clk) disable iff (!rst_b)
        blocked |=> other_fault && alert && $stable(scaling_link_id);
    endproperty
    a_block: assert property (p_block)
        else $error("blocked write not flagged");

    property p_set_wins;
        @(posedge ref_clk) disable iff (!rst_b)
        blocked && other_fault_clear |=> other_fault;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a new fault");

    property p_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        !blocked && other_fault_clear |=> !other_fault;
    endproperty
    a_clear: assert property (p_clear)
        else $error("fault not cleared");

    property p_ack;
        @(posedge ref_clk) disable iff (!rst_b)
        cmd_write |-> cmd_ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("write not acknowledged");

    property p_store;
        @(posedge ref_clk) disable iff (!rst_b)
        store_ok |=> scaling_link_id == $past(cmd_wdata[`VSMA_ID_MSB:0]);
    endproperty
    a_store: assert property (p_store)
        else $error("address not stored");

    property p_match;
        @(posedge ref_clk) disable iff (!rst_b)
        store_ok |=> link_addr_match
            == (link_addr == $past(cmd_wdata[`VSMA_ID_MSB:0]));
    endproperty
    a_match: assert property (p_match)
        else $error("match wrong");

    property p_rsvd;
        @(posedge ref_clk) disable iff (!rst_b)
        cmd_rdata[15:4] == `VSMA_RSVD_ZERO;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits set");

    property p_rdata;
        @(posedge ref_clk) disable iff (!rst_b)
        addr_sel |=> cmd_rdata == {`VSMA_RSVD_ZERO, $past(scaling_link_id)};
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data wrong");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        !store_ok |=> $stable(scaling_link_id);
    endproperty
    a_hold: assert property (p_hold)
        else $error("id changed");

    property p_only_bus;
        @(posedge ref_clk) disable iff (!rst_b)
        $changed(scaling_link_id) |-> $past(store_ok);
    endproperty
    a_only_bus: assert property (p_only_bus)
        else $error("id changed without bus write");
endmodule

/* File: design/vsma_regs.svh */
// Overview of operation
// - Power cycle: enable 0 gives bus mode, else scaling or startup mode.
// - Startup mode moves to scaling once enable is 1 and startup is 0.
// - A dedicated register holds the link identifier for scaling use.
// - Write with both channels scaling: acked, ignored, fault set, alert.
// - With only one channel scaling, address writes are stored normally.
// - Address in bits 3:0, default 0101b; upper bits reserved, read zero.
// - Address is matched only on the scaling link, not the management bus.
`ifndef VSMA_REGS_SVH
`define VSMA_REGS_SVH
`define VSMA_ADDR_CMD 8'hEA
`define VSMA_ID_RESET 4'h5
`define VSMA_ID_MSB 3
`define VSMA_DATA_W 16
`define VSMA_RSVD_ZERO 12'h000
`define VSMA_RDATA_IDLE 16'h0000
`define VSMA_SYNC_RESET 2'h0
`endif

/* File: design/vsma_pkg.sv */
package vsma_pkg;
    typedef enum logic [1:0] {
        VSMA_MGMT = 2'b00,
        VSMA_SCALE = 2'b01,
        VSMA_STARTUP = 2'b11
    } vsma_mode_type;
endpackage

/* File: design/vsma_chan_if.sv */
`timescale 1ns/1ns
interface vsma_chan_if;
    logic enable_flag;
    logic startup_flag;
    logic power_cycle;
    logic [1:0] mode;
    modport ctl (input enable_flag, startup_flag, power_cycle);
    modport fsm (input enable_flag, startup_flag, power_cycle, output mode);
endinterface

/* File: design/vsma_mode_fsm.sv */
`timescale 1ns/1ns
module vsma_mode_fsm
    import vsma_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Flags and mode
    vsma_chan_if.fsm ch
);
    vsma_mode_type mode;
    vsma_mode_type next_mode;
    vsma_mode_type boot_mode;

    // ==========================================
    // Mode selection
    assign boot_mode = !ch.enable_flag ? VSMA_MGMT :
        (ch.startup_flag ? VSMA_STARTUP : VSMA_SCALE);

    always_comb begin
        next_mode = mode;
        if (ch.power_cycle) begin
            next_mode = boot_mode;
        end else begin
            case (mode)
                VSMA_MGMT: next_mode = VSMA_MGMT;
                VSMA_SCALE: begin
                    if (ch.startup_flag) begin
                        next_mode = VSMA_STARTUP;
                    end
                end
                VSMA_STARTUP: begin
                    if (ch.enable_flag && !ch.startup_flag) begin
                        next_mode = VSMA_SCALE;
                    end
                end
                default: next_mode = VSMA_MGMT;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= VSMA_MGMT;
        end else begin
            mode <= next_mode;
        end
    end

    assign ch.mode = mode;

    property p_boot;
        @(posedge ref_clk) disable iff (!rst_b)
        ch.power_cycle |=> mode == $past(boot_mode);
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot mode wrong");

    property p_stup;
        @(posedge ref_clk) disable iff (!rst_b)
        mode == VSMA_STARTUP && ch.enable_flag && !ch.startup_flag
        |=> mode == VSMA_SCALE;
    endproperty
    a_stup: assert property (p_stup)
        else $error("startup did not leave");

    property p_keep;
        @(posedge ref_clk) disable iff (!rst_b)
        !ch.power_cycle && mode == VSMA_MGMT |=> mode == VSMA_MGMT;
    endproperty
    a_keep: assert property (p_keep)
        else $error("bus mode left");

    property p_to_stup;
        @(posedge ref_clk) disable iff (!rst_b)
        !ch.power_cycle && mode == VSMA_SCALE && ch.startup_flag
        |=> mode == VSMA_STARTUP;
    endproperty
    a_to_stup: assert property (p_to_stup)
        else $error("scaling did not enter startup");
endmodule

/* File: tb/vsma_host.sv */
`timescale 1ns/1ns
module vsma_host (
    // Clock
    input wire logic ref_clk,
    // Command port
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_ack
);
    logic seen_ack;
    initial {cmd_write, cmd_code, cmd_wdata} = '0;
    // Address is only ever set from the management side
    task wr(input logic [7:0] c, input logic [15:0] d);
        {cmd_write, cmd_code, cmd_wdata} <= {1'b1, c, d};
        @(posedge ref_clk);
        seen_ack = cmd_ack;
        {cmd_write, cmd_wdata} <= {1'b0, ~d};
    endtask
    task rd(input logic [7:0] c, output logic [15:0] d);
        cmd_code <= c;
        repeat (2) @(posedge ref_clk);
        d = cmd_rdata;
    endtask
endmodule

/* File: tb/vsma_top_tb_top.sv */
`timescale 1ns/1ns
module vsma_top_tb_top;
    import vsma_pkg::*;
    logic ref_clk = 0, rst_b = 0, pc = 0, clr = 0;
    logic [1:0] en = 0, st = 0;
    logic [3:0] la = 0, id = 4'h5;
    logic [15:0] r, d;
    wire logic [15:0] rd, wd;
    wire logic ack, lm, flt, al, wr;
    wire logic [1:0] m0, m1;
    wire logic [7:0] cc;
    int n_fail = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    vsma_host H(.ref_clk(ref_clk), .cmd_write(wr), .cmd_code(cc),
        .cmd_wdata(wd), .cmd_rdata(rd), .cmd_ack(ack));
    vsma_top DUT(.ref_clk(ref_clk), .rst_b(rst_b),
        .scaling_enable_flag(en), .scaling_startup_flag(st),
        .power_cycle(pc), .cmd_write(wr), .cmd_code(cc),
        .cmd_wdata(wd), .cmd_rdata(rd), .cmd_ack(ack),
        .link_addr(la), .link_addr_match(lm), .other_fault(flt),
        .other_fault_clear(clr), .alert(al), .chan_mode0(m0),
        .chan_mode1(m1));
    task chk(string s, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", s, e, g);
        end
    endtask
    task give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Flags need sync plus one cycle before a mode moves
    task flags(logic [1:0] e, logic [1:0] s, logic p, logic [3:0] m);
        en <= e;
        st <= s;
        cyc(4);
        pc <= p;
        cyc(1);
        pc <= 0;
        cyc(2);
        chk("modes", {12'h0, m}, {12'h0, m1, m0});
        $display("mode test done");
    endtask
    task wrid(logic [15:0] v, logic blk);
        H.wr(8'hEA, v);
        chk("ack", 1, H.seen_ack);
        if (!blk) id = v[3:0];
        H.rd(8'hEA, d);
        chk("id", {12'h0, id}, d);
        la <= id;
        cyc(1);
        chk("match", 1, lm);
        la <= ~id;
        cyc(1);
        chk("nomatch", 0, lm);
        chk("fault", blk, flt);
        chk("alert", blk, al);
        $display("address test done");
    endtask
    initial begin
        r = 16'($urandom(80));
        cyc(2);
        rst_b <= 1;
        cyc(1);
        H.rd(8'hEA, d);
        chk("reset id", 16'h0005, d);
        repeat (4) begin
            r = 16'($urandom);
            wrid(r, 0);
        end
        flags(2'b11, 2'b11, 1, 4'hF);
        flags(2'b11, 2'b00, 0, 4'h5);
        wrid(16'hFFFF ^ {12'h0, id}, 1);
        clr <= 1;
        cyc(1);
        clr <= 0;
        cyc(1);
        chk("cleared", 0, flt);
        flags(2'b01, 2'b00, 1, 4'h1);
        wrid(16'($urandom), 0);
        flags(2'b01, 2'b01, 0, 4'h3);
        flags(2'b00, 2'b01, 0, 4'h3);
        flags(2'b00, 2'b00, 1, 4'h0);
        give_verdict;
    end
endmodule
